/* src/dma_desc_pkg.sv */
package dma_desc_pkg;
  // Descriptor byte 6 fields
  localparam int WIDE_BIT = 7;
  localparam int MODE_HI = 6;
  localparam int MODE_LO = 5;
  localparam int START_SOURCE_SEL_HI = 4;
  localparam int START_SOURCE_SEL_LO = 0;
  // Descriptor byte 7 fields
  localparam int SRC_HI = 7;
  localparam int SRC_LO = 6;
  localparam int DST_HI = 5;
  localparam int DST_LO = 4;
  localparam int IRQEN_BIT = 3;
  localparam int MASK8_BIT = 2;
  localparam int PRIO_HI = 1;
  localparam int PRIO_LO = 0;
  // Descriptor byte 4 variable-length field
  localparam int VAR_COUNT_MODE_HI = 7;
  localparam int VAR_COUNT_MODE_LO = 5;

  // APB register offsets
  localparam logic [7:0] OFS_DESC_LO = 8'h00;
  localparam logic [7:0] OFS_DESC_HI = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_COUNT = 8'h18;

  localparam logic [31:0] DESC_RESET = 32'h0000_0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  localparam logic [4:0] START_SOURCE_SEL_NONE = 5'h00;
  localparam logic [4:0] START_SOURCE_SEL_CHAIN = 5'h01;
  localparam logic [4:0] START_SOURCE_SEL_PERIPH0 = 5'h02;

  localparam logic [2:0] VAR_COUNT_MODE_FIXED = 3'h0;
  localparam logic [2:0] VAR_COUNT_MODE_PLUS1 = 3'h1;
  localparam logic [2:0] VAR_COUNT_MODE_EXACT = 3'h2;
  localparam logic [2:0] VAR_COUNT_MODE_PLUS2 = 3'h3;
  localparam logic [2:0] VAR_COUNT_MODE_PLUS3 = 3'h4;
  localparam logic [2:0] VAR_COUNT_MODE_ALT = 3'h7;

  localparam logic [1:0] PRIO_LOW = 2'h0;
  localparam logic [1:0] PRIO_NORMAL = 2'h1;
  localparam logic [1:0] PRIO_HIGH = 2'h2;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_BLOCK = 2'h1,
    MODE_RSINGLE = 2'h2,
    MODE_RBLOCK = 2'h3
  } xfer_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REQ = 4'b0010,
    ST_STEP = 4'b0100,
    ST_DONE = 4'b1000
  } chan_state_t;
endpackage

/* src/addr_stepper.sv */
`timescale 1ns/100ps
// One address stepped per transfer by 0, +1, +2 or -1 units
module addr_stepper
  import dma_desc_pkg::*;
#(
  parameter int AW = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic load,
  input wire logic [AW-1:0] start_addr,
  input wire logic step,
  input wire logic [1:0] step_sel,
  input wire logic wide,
  // Address
  output logic [AW-1:0] addr
);
  logic [AW-1:0] addr_ff;
  logic [AW-1:0] unit;
  logic [AW-1:0] nxt_addr;

  always_comb begin
    unit = wide ? AW'(2) : AW'(1);
    case (step_sel)
      2'h0: nxt_addr = addr_ff;
      2'h1: nxt_addr = addr_ff + unit;
      2'h2: nxt_addr = addr_ff + (unit << 1);
      2'h3: nxt_addr = addr_ff - unit;
      default: nxt_addr = addr_ff;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addr_ff <= '0;
    end else if (load) begin
      addr_ff <= start_addr;
    end else if (step) begin
      addr_ff <= nxt_addr;
    end
  end

  assign addr = addr_ff;
endmodule // addr_stepper

/* src/dma_channel_descriptor_decode.sv */
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
module dma_channel_descriptor_decode
  import dma_desc_pkg::*;
#(
  parameter int AW = 16,
  parameter int NPERIPH = 30
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger sources
  input wire logic prev_chan_done,
  input wire logic [NPERIPH-1:0] periph_start_source_sel,
  // Memory bus arbitration
  input wire logic cpu_mem_req,
  output logic dma_mem_req,
  output logic dma_grant,
  output logic cpu_grant,
  // Transfer data path
  input wire logic [15:0] rd_data,
  output logic [AW-1:0] src_addr,
  output logic [AW-1:0] dst_addr,
  output logic wide_transfer_sel,
  output logic [1:0] xfer_mode_sel,
  output logic chan_done,
  // Interrupt
  output logic irq
);
  // Descriptor bytes 4..7 (low word) and start addresses (high word)
  logic [31:0] desc_lo_ff;
  logic [31:0] desc_hi_ff;
  logic [12:0] max_count_ff;
  logic arm_ff;
  logic manual_kick_reg_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;
  logic [12:0] xfer_count_ff;
  logic [12:0] done_cnt_ff;
  logic first_ff;
  logic lost_ff;
  chan_state_t state_ff;
  chan_state_t nxt_state;

  logic [7:0] byte6;
  logic [7:0] byte7;
  logic [2:0] var_count_mode;
  logic [4:0] start_source_sel;
  logic [1:0] source_step;
  logic [1:0] dest_step;
  logic done_irq_enable;
  logic len_bit7_mask;
  logic [1:0] prio;
  logic start_source_sel_hit;
  logic wr;
  logic grant;
  logic is_var;
  logic [12:0] len_raw;
  logic [12:0] len_adj;
  logic [12:0] len_cap;
  logic last_unit;
  logic repeated;
  logic block_mode;

  assign byte6 = desc_lo_ff[23:16];
  assign byte7 = desc_lo_ff[31:24];
  assign var_count_mode = desc_lo_ff[VAR_COUNT_MODE_HI:VAR_COUNT_MODE_LO];
  assign wide_transfer_sel = byte6[WIDE_BIT];
  assign xfer_mode_sel = byte6[MODE_HI:MODE_LO];
  assign start_source_sel = byte6[START_SOURCE_SEL_HI:START_SOURCE_SEL_LO];
  assign source_step = byte7[SRC_HI:SRC_LO];
  assign dest_step = byte7[DST_HI:DST_LO];
  assign done_irq_enable = byte7[IRQEN_BIT];
  assign len_bit7_mask = byte7[MASK8_BIT];
  assign prio = byte7[PRIO_HI:PRIO_LO];
  assign repeated = xfer_mode_sel == MODE_RSINGLE || xfer_mode_sel == MODE_RBLOCK;
  assign block_mode = xfer_mode_sel == MODE_BLOCK || xfer_mode_sel == MODE_RBLOCK;

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  // Trigger selection
  always_comb begin
    case (start_source_sel)
      START_SOURCE_SEL_NONE: start_source_sel_hit = 1'b0;
      START_SOURCE_SEL_CHAIN: start_source_sel_hit = prev_chan_done;
      default: start_source_sel_hit = (int'(start_source_sel) - int'(START_SOURCE_SEL_PERIPH0) < NPERIPH) ?
        periph_start_source_sel[int'(start_source_sel) - int'(START_SOURCE_SEL_PERIPH0)] : 1'b0;
    endcase
  end
  // Arbitration against the CPU
  always_comb begin
    dma_mem_req = state_ff == ST_REQ;
    case (prio)
      PRIO_LOW: grant = dma_mem_req && !cpu_mem_req;
      PRIO_HIGH: grant = dma_mem_req;
      default: grant = dma_mem_req && (!cpu_mem_req || lost_ff);
    endcase
    dma_grant = grant;
    cpu_grant = cpu_mem_req && !grant;
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lost_ff <= 1'b0;
    end else if (dma_mem_req && cpu_mem_req) begin
      lost_ff <= !grant;
    end
  end
  // Variable length count from first unit
  always_comb begin
    is_var = var_count_mode != VAR_COUNT_MODE_FIXED && var_count_mode != VAR_COUNT_MODE_ALT;
    if (wide_transfer_sel) begin
      len_raw = rd_data[12:0];
    end else if (len_bit7_mask) begin
      len_raw = {6'h00, rd_data[6:0]};
    end else begin
      len_raw = {5'h00, rd_data[7:0]};
    end
    case (var_count_mode)
      VAR_COUNT_MODE_PLUS1: len_adj = len_raw + 13'h0001;
      VAR_COUNT_MODE_EXACT: len_adj = len_raw;
      VAR_COUNT_MODE_PLUS2: len_adj = len_raw + 13'h0002;
      VAR_COUNT_MODE_PLUS3: len_adj = len_raw + 13'h0003;
      default: len_adj = max_count_ff;
    endcase
    len_cap = (len_adj > max_count_ff) ? max_count_ff : len_adj;
    if (len_cap == 13'h0000) begin
      len_cap = 13'h0001;
    end
  end
  assign last_unit = (done_cnt_ff + 13'h0001) >= xfer_count_ff;
  // Channel state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (arm_ff && (start_source_sel_hit || manual_kick_reg_ff)) begin
          nxt_state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (grant) begin
          nxt_state = ST_STEP;
        end
      end
      ST_STEP: begin
        if ((first_ff && is_var) ? len_cap == 13'h0001 : last_unit) begin
          nxt_state = ST_DONE;
        end else if (block_mode) begin
          nxt_state = ST_REQ;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  // Transfer counting
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      done_cnt_ff <= '0;
      xfer_count_ff <= '0;
      first_ff <= 1'b1;
    end else if (state_ff == ST_IDLE && nxt_state == ST_REQ && first_ff) begin
      done_cnt_ff <= '0;
      xfer_count_ff <= max_count_ff;
    end else if (state_ff == ST_STEP) begin
      done_cnt_ff <= done_cnt_ff + 13'h0001;
      first_ff <= 1'b0;
      if (first_ff && is_var) begin
        xfer_count_ff <= len_cap;
      end
      if (nxt_state == ST_DONE) begin
        first_ff <= 1'b1;
      end
    end
  end
  // Registers and arm
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      desc_lo_ff <= DESC_RESET;
      desc_hi_ff <= DESC_RESET;
      max_count_ff <= '0;
      arm_ff <= 1'b0;
    end else begin
      if (wr && paddr == OFS_DESC_LO) begin
        desc_lo_ff <= pwdata;
        max_count_ff <= {pwdata[4:0], pwdata[15:8]};
      end
      if (wr && paddr == OFS_DESC_HI) begin
        desc_hi_ff <= pwdata;
      end
      if (wr && paddr == OFS_CTRL) begin
        arm_ff <= pwdata[0];
      end else if (state_ff == ST_DONE && !repeated) begin
        arm_ff <= 1'b0;
      end
    end
  end
  // Manual kick: set by write, cleared on grant
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      manual_kick_reg_ff <= 1'b0;
    end else if (wr && paddr == OFS_CTRL && pwdata[1]) begin
      manual_kick_reg_ff <= 1'b1;
    end else if (grant) begin
      manual_kick_reg_ff <= 1'b0;
    end
  end

  // Interrupt status: bit0 done, bit1 trigger while busy
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_stat_ff <= IRQ_RESET;
      irq_mask_ff <= IRQ_RESET;
    end else begin
      if (wr && paddr == OFS_IRQ_MASK) begin
        irq_mask_ff <= pwdata[1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if (wr && paddr == OFS_IRQ_STAT && pwdata[i]) begin
          irq_stat_ff[i] <= 1'b0;
        end
      end
      if (state_ff == ST_DONE && done_irq_enable) begin
        irq_stat_ff[0] <= 1'b1;
      end
      if (start_source_sel_hit && state_ff != ST_IDLE) begin
        irq_stat_ff[1] <= 1'b1;
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chan_done <= 1'b0;
    end else begin
      chan_done <= nxt_state == ST_DONE;
    end
  end

  // Read mux
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      case (paddr)
        OFS_DESC_LO: prdata <= desc_lo_ff;
        OFS_DESC_HI: prdata <= desc_hi_ff;
        OFS_CTRL: prdata <= {30'h0000_0000, manual_kick_reg_ff, arm_ff};
        OFS_STATUS: prdata <= {28'h000_0000, state_ff};
        OFS_IRQ_STAT: prdata <= {30'h0000_0000, irq_stat_ff};
        OFS_IRQ_MASK: prdata <= {30'h0000_0000, irq_mask_ff};
        OFS_COUNT: prdata <= {3'h0, done_cnt_ff, 3'h0, xfer_count_ff};
        default: begin
          prdata <= '0;
          pslverr <= !pwrite;
        end
      endcase
    end
  end

  addr_stepper #(.AW(AW)) u_src (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(wr && paddr == OFS_DESC_HI),
    .start_addr(pwdata[AW-1:0]),
    .step(state_ff == ST_STEP),
    .step_sel(source_step),
    .wide(wide_transfer_sel),
    .addr(src_addr)
  );

  addr_stepper #(.AW(AW)) u_dst (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(wr && paddr == OFS_DESC_HI),
    .start_addr(pwdata[31:32-AW]),
    .step(state_ff == ST_STEP),
    .step_sel(dest_step),
    .wide(wide_transfer_sel),
    .addr(dst_addr)
  );
endmodule // dma_channel_descriptor_decode

/* test/dma_desc_monitor.sv */
`timescale 1ns/100ps
module dma_desc_monitor
  import dma_desc_pkg::*;
#(
  parameter int AW = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Bus and data path
  input wire logic cpu_mem_req,
  input wire logic dma_mem_req,
  input wire logic dma_grant,
  input wire logic cpu_grant,
  input wire logic [AW-1:0] src_addr,
  input wire logic [AW-1:0] dst_addr,
  input wire logic wide_transfer_sel,
  input wire logic [1:0] xfer_mode_sel
);
  logic [31:0] desc_ff;
  logic [AW-1:0] src_exp_ff;
  logic [AW-1:0] dst_exp_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  function automatic logic [AW-1:0] stepv(input logic [1:0] s, input logic w);
    logic [AW-1:0] u;
    u = w ? AW'(2) : AW'(1);
    return (s == 2'h3) ? -u : u * AW'(s);
  endfunction
  // Shadow of descriptor bytes 4 to 7
  always_ff @(posedge ref_clk) begin
    if (reset)
      desc_ff <= DESC_RESET;
    else if (psel && penable && pwrite && paddr == OFS_DESC_LO)
      desc_ff <= pwdata;
  end
  // Addresses due after a granted unit
  always_ff @(posedge ref_clk) begin
    if (dma_grant) begin
      src_exp_ff <= src_addr + stepv(desc_ff[31:30], wide_transfer_sel);
      dst_exp_ff <= dst_addr + stepv(desc_ff[29:28], wide_transfer_sel);
    end
  end
  a_mode_field: assert property (xfer_mode_sel == desc_ff[22:21])
    else $error("transfer mode output differs from descriptor");
  a_width_field: assert property (wide_transfer_sel == desc_ff[23])
    else $error("width output differs from descriptor");
  a_low_defer: assert property (desc_ff[25:24] == PRIO_LOW && cpu_mem_req |-> !dma_grant)
    else $error("low priority channel beat the CPU");
  a_grant_cause: assert property (dma_grant |-> dma_mem_req)
    else $error("grant without a channel request");
  a_grant_excl: assert property (!(dma_grant && cpu_grant))
    else $error("both parties granted");
  a_high_win: assert property (desc_ff[25:24] == PRIO_HIGH && dma_mem_req |-> dma_grant)
    else $error("high priority request not granted");
  a_normal_turn: assert property (desc_ff[24] && !desc_ff[25] && dma_mem_req && !dma_grant
    |=> dma_grant || !dma_mem_req)
    else $error("normal priority lost twice in a row");
  a_src_step: assert property (dma_grant |=> ##1 src_addr == src_exp_ff)
    else $error("source address stepped wrongly");
  a_dst_step: assert property (dma_grant |=> ##1 dst_addr == dst_exp_ff)
    else $error("destination address stepped wrongly");
endmodule // dma_desc_monitor

/* test/mem_bus_model.sv */
`timescale 1ns/100ps
module mem_bus_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Behaviour chosen by the bench
  input wire logic [1:0] cpu_mode,
  input wire logic [15:0] unit_word,
  // Bus side
  input wire logic dma_grant,
  output logic cpu_mem_req,
  output logic [15:0] rd_data
);
  logic gnt_ff;
  logic tog_ff;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gnt_ff <= 1'h0;
      tog_ff <= 1'h0;
    end else begin
      gnt_ff <= dma_grant;
      tog_ff <= ~tog_ff;
    end
  end
  // Mode 1 keeps the CPU asking, mode 2 every other cycle
  assign cpu_mem_req = cpu_mode == 2'h1 || (cpu_mode == 2'h2 && tog_ff);
  // Unit data only after a grant, scrambled otherwise
  assign rd_data = gnt_ff ? unit_word : ~unit_word;
endmodule // mem_bus_model

/* test/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import dma_desc_pkg::*;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic prev_chan_done = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [29:0] periph_start_source_sel = 30'h0000_0000;
  logic [15:0] unit_word = 16'h0000;
  logic [1:0] cpu_mode = 2'h0;
  logic [31:0] prdata, rd, r, seed;
  logic pready, pslverr, err, cpu_mem_req, dma_mem_req, dma_grant, cpu_grant;
  logic [15:0] rd_data, src_addr, dst_addr, s0, d0;
  logic wide_transfer_sel, chan_done, irq;
  logic [1:0] xfer_mode_sel;
  logic [2:0] vl;
  logic [1:0] md;
  logic [29:0] hit;
  int fails = 0;
  int n_checks = 0;
  int n, len, k;
  always #2.5 ref_clk = ~ref_clk;
  dma_channel_descriptor_decode #(.AW(16), .NPERIPH(30)) dut_u (.ref_clk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .prev_chan_done,
    .periph_start_source_sel, .cpu_mem_req, .dma_mem_req, .dma_grant, .cpu_grant, .rd_data, .src_addr,
    .dst_addr, .wide_transfer_sel, .xfer_mode_sel, .chan_done, .irq);
  mem_bus_model far_u (.ref_clk, .reset, .cpu_mode, .unit_word, .dma_grant, .cpu_mem_req,
    .rd_data);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] step_of(input logic [1:0] s, input logic w);
    return (s == 2'h3) ? -(16'h0001 << w) : (16'h0001 << w) * 16'(s);
  endfunction
  function automatic int units(input logic [2:0] c, input int l, input logic w, input logic m,
    input logic [15:0] u);
    int v;
    v = w ? int'(u[12:0]) : (m ? int'(u[6:0]) : int'(u[7:0]));
    if (c == VAR_COUNT_MODE_FIXED || c == VAR_COUNT_MODE_ALT)
      return l;
    v = v + (c == VAR_COUNT_MODE_PLUS1 ? 1 : c == VAR_COUNT_MODE_PLUS2 ? 2 : c == VAR_COUNT_MODE_PLUS3 ? 3 : 0);
    return v < l ? v : l;
  endfunction
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    chk("pready", pready, 32'h0000_0001);
    if (k >= 20)
      finish_test();
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wait_done();
    k = 0;
    while (chan_done !== 1'h1 && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    chk("chan_done", chan_done, 32'h0000_0001);
    if (k >= 2000)
      finish_test();
  endtask
  task automatic pulse(input logic [29:0] t, input logic p);
    @(posedge ref_clk);
    periph_start_source_sel <= t;
    prev_chan_done <= p;
    @(posedge ref_clk);
    periph_start_source_sel <= 30'h0000_0000;
    prev_chan_done <= 1'h0;
  endtask
  initial begin
    seed = 32'h0000_003d;
    repeat (5) @(posedge ref_clk);
    reset <= 1'h0;
    apb(1'h0, OFS_DESC_LO, 32'h0000_0000);
    chk("desc reset", rd, DESC_RESET);
    apb(1'h0, 8'h1c, 32'h0000_0000);
    chk("unmapped error", err, 32'h0000_0001);
    apb(1'h1, 8'h1c, 32'h0000_0000);
    chk("unmapped write no error", err, 32'h0000_0000);
    for (int c = 0; c < 32; c++) begin
      hit = c < 2 ? 30'h0000_0000 : 30'h0000_0001 << (c - 2);
      apb(1'h1, OFS_DESC_LO, {8'h00, 3'h0, 5'(c), 16'h0100});
      apb(1'h1, OFS_CTRL, 32'h0000_0001);
      pulse(~hit, c != 1);
      apb(1'h0, OFS_CTRL, 32'h0000_0000);
      chk("armed after other sources", rd[0], 32'h0000_0001);
      if (c == 0)
        apb(1'h1, OFS_CTRL, 32'h0000_0003);
      else
        pulse(hit, c == 1);
      wait_done();
    end
    for (int i = 0; i < 18; i++) begin
      r = rnd();
      vl = (i % 6 == 5) ? VAR_COUNT_MODE_ALT : 3'(i % 6);
      len = int'(r[2:0]) + 1;
      s0 = r[31:16];
      d0 = 16'(rnd() >> 8);
      unit_word <= {r[23:16], 8'h80 | (8'(r[12:11]) + 8'h01)};
      cpu_mode <= (i % 3 == 0) ? 2'h2 : 2'h1;
      md = (i % 2 == 1) ? MODE_RBLOCK : MODE_BLOCK;
      apb(1'h1, OFS_DESC_LO, {r[10:5], 2'(i % 3), r[4], md, 5'h00, 8'(len), vl, 5'h00});
      apb(1'h1, OFS_DESC_HI, {d0, s0});
      apb(1'h1, OFS_IRQ_MASK, {31'h0, r[13]});
      apb(1'h1, OFS_CTRL, 32'h0000_0003);
      wait_done();
      n = units(vl, len, r[4], r[5], unit_word);
      chk("src_addr", src_addr, 16'(s0 + step_of(r[10:9], r[4]) * 16'(n)));
      chk("dst_addr", dst_addr, 16'(d0 + step_of(r[8:7], r[4]) * 16'(n)));
      apb(1'h0, OFS_COUNT, 32'h0000_0000);
      chk("units done", rd[28:16], 13'(n));
      apb(1'h0, OFS_IRQ_STAT, 32'h0000_0000);
      chk("done flag", rd[0], r[6]);
      chk("irq", irq, r[6] & r[13]);
      apb(1'h1, OFS_IRQ_STAT, 32'h0000_0003);
      apb(1'h0, OFS_IRQ_STAT, 32'h0000_0000);
      chk("flags cleared", rd[1:0], 32'h0000_0000);
      chk("irq cleared", irq, 32'h0000_0000);
      apb(1'h0, OFS_CTRL, 32'h0000_0000);
      chk("arm after done", rd[0], md[1]);
    end
    finish_test();
  end
endmodule // testbench
bind dma_channel_descriptor_decode dma_desc_monitor #(.AW(AW)) mon_u (.ref_clk, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .cpu_mem_req, .dma_mem_req, .dma_grant, .cpu_grant,
  .src_addr, .dst_addr, .wide_transfer_sel, .xfer_mode_sel);
